// *** core/tpwm_regs.svh ***
// Timing counts, field positions and reset values for the timer-based PWM unit.
// Assumes inclusion by the package and the core; definitions only.
`ifndef TPWM_REGS_SVH
`define TPWM_REGS_SVH
`define TPWM_NUM_MATCH      7
`define TPWM_NUM_OUT        6
`define TPWM_CNT_W          32
`define TPWM_CNT_RST        32'h0000_0000
`define TPWM_MATCH_RST      32'h0000_0000
`define TPWM_MCTL_INT_BIT   0
`define TPWM_MCTL_CLR_BIT   1
`define TPWM_MCTL_STOP_BIT  2
`define TPWM_CAP_W          2
`endif

// *** core/tpwm_pkg.sv ***
// Types shared by the timer-based PWM unit and its users.
// Assumes tpwm_regs.svh is on the include path.
`include "tpwm_regs.svh"
package tpwm_pkg;
    typedef logic [`TPWM_CNT_W-1:0] tpwm_word_t;
    typedef enum logic [0:0] {
        TPWM_MODE_TIMER   = 1'h0,
        TPWM_MODE_COUNTER = 1'h1
    } tpwm_mode_t;
    typedef struct packed {
        logic       counter_en;
        logic       counter_reset;
        logic       pwm_mode_en;
        tpwm_mode_t count_mode;
        logic [`TPWM_CAP_W-1:0] cap_sel;
        logic       cap_rise;
        logic       cap_fall;
    } tpwm_ctrl_t;
    typedef struct packed {
        logic [2:0] action;
    } tpwm_mctl_t;
    typedef struct packed {
        logic [`TPWM_NUM_OUT-1:0] out_en;
        logic [`TPWM_NUM_OUT-1:0] dbl_edge;
    } tpwm_ocfg_t;
endpackage : tpwm_pkg

// *** core/tpwm_core.sv ***
// Timer-based PWM unit: prescaled 32-bit counter, seven shadowed match registers.
// Assumes all inputs synchronous to ref_clk; software drives match writes as ports.
`timescale 1ns/100ps
`include "tpwm_regs.svh"
module tpwm_core (
    // Clock and reset.
    input  wire logic                          ref_clk,
    input  wire logic                          reset,
    // Control and configuration.
    input  wire tpwm_pkg::tpwm_ctrl_t          ctrl,
    input  wire tpwm_pkg::tpwm_word_t          prescale_max,
    input  wire tpwm_pkg::tpwm_ocfg_t          ocfg,
    input  wire tpwm_pkg::tpwm_mctl_t [6:0]    mctl,
    // Match write port and release strobes.
    input  wire logic                          match_wr,
    input  wire logic [2:0]                    match_sel,
    input  wire tpwm_pkg::tpwm_word_t          match_wdata,
    input  wire logic [6:0]                    latch_en,
    // Capture inputs used as count source.
    input  wire logic [3:0]                    cap_in,
    // Status and outputs.
    output tpwm_pkg::tpwm_word_t               count_val,
    output tpwm_pkg::tpwm_word_t               prescale_val,
    output logic [6:0]                         match_irq,
    output logic [6:0]                         latch_pending,
    output logic [`TPWM_NUM_OUT-1:0]           pwm_out
);
    import tpwm_pkg::*;

    tpwm_word_t               cnt_ff,  nxt_cnt;
    tpwm_word_t               pre_ff,  nxt_pre;
    tpwm_word_t               shadow_ff [7];
    tpwm_word_t               nxt_shadow [7];
    tpwm_word_t               active_ff [7];
    tpwm_word_t               nxt_active [7];
    logic [6:0]               pend_ff, nxt_pend;
    logic [6:0]               irq_ff,  nxt_irq;
    logic                     stop_ff, nxt_stop;
    logic                     cap_ff,  nxt_cap;
    logic [`TPWM_NUM_OUT-1:0] out_ff,  nxt_out;
    logic [6:0]               hit;
    logic                     tick;
    logic                     cap_edge;
    logic                     cap_now;

    assign count_val     = cnt_ff;
    assign prescale_val  = pre_ff;
    assign match_irq     = irq_ff;
    assign latch_pending = pend_ff;
    assign pwm_out       = out_ff;

    // Count source: prescaler input is the clock or a capture edge.
    always_comb begin
        cap_now  = cap_in[ctrl.cap_sel];
        cap_edge = (ctrl.cap_rise & cap_now & ~cap_ff) |
                   (ctrl.cap_fall & ~cap_now & cap_ff);
        tick     = ctrl.counter_en & ~stop_ff &
                   ((ctrl.count_mode == TPWM_MODE_TIMER) | cap_edge);
    end

    always_comb begin
        for (int i = 0; i < `TPWM_NUM_MATCH; i++) begin
            // A held counter reset is no increment edge, so it must not move pins or shadows.
            hit[i] = tick && !ctrl.counter_reset && (pre_ff == prescale_max) &&
                     (cnt_ff == active_ff[i]);
        end
    end

    // Counter, prescaler and match actions.
    always_comb begin
        nxt_cap  = cap_now;
        nxt_pre  = pre_ff;
        nxt_cnt  = cnt_ff;
        nxt_stop = stop_ff;
        nxt_irq  = '0;
        if (ctrl.counter_reset) begin
            nxt_pre = `TPWM_CNT_RST;
            nxt_cnt = `TPWM_CNT_RST;
        end else if (tick) begin
            if (pre_ff == prescale_max) begin
                nxt_pre = `TPWM_CNT_RST;
                nxt_cnt = cnt_ff + 32'h0000_0001;
            end else begin
                nxt_pre = pre_ff + 32'h0000_0001;
            end
            for (int i = 0; i < `TPWM_NUM_MATCH; i++) begin
                if (hit[i]) begin
                    nxt_irq[i] = mctl[i].action[`TPWM_MCTL_INT_BIT];
                    if (mctl[i].action[`TPWM_MCTL_CLR_BIT] || (ctrl.pwm_mode_en && i == 0)) begin
                        nxt_cnt = `TPWM_CNT_RST;
                    end
                    if (mctl[i].action[`TPWM_MCTL_STOP_BIT]) begin
                        nxt_stop = 1'b1;
                    end
                end
            end
        end
        if (!ctrl.counter_en) begin
            nxt_stop = 1'b0;
        end
    end

    // Match shadows: written anywhere, applied at a period restart in PWM mode, at once outside it or while the counter is disabled.
    always_comb begin
        nxt_pend = pend_ff;
        for (int i = 0; i < `TPWM_NUM_MATCH; i++) begin
            nxt_shadow[i] = shadow_ff[i];
            nxt_active[i] = active_ff[i];
        end
        if (match_wr && match_sel < 3'h7) begin
            nxt_shadow[match_sel] = match_wdata;
        end
        nxt_pend = pend_ff | latch_en;
        for (int i = 0; i < `TPWM_NUM_MATCH; i++) begin
            if (pend_ff[i] && (!ctrl.pwm_mode_en || hit[0] || !ctrl.counter_en)) begin
                nxt_active[i] = shadow_ff[i];
                nxt_pend[i]   = latch_en[i];
            end
        end
    end

    // Edge logic; output n rises on match 0 and falls on match n+1, or uses matches n and n+1 when double-edged (n > 0 only).
    always_comb begin
        nxt_out = out_ff;
        for (int n = 0; n < `TPWM_NUM_OUT; n++) begin
            if (!ctrl.pwm_mode_en || !ocfg.out_en[n]) begin
                nxt_out[n] = 1'b0;
            end else if (ocfg.dbl_edge[n] && n > 0) begin
                if (hit[n + 1]) begin
                    nxt_out[n] = 1'b0;
                end else if (hit[n]) begin
                    nxt_out[n] = 1'b1;
                end
            end else begin
                if (hit[n + 1]) begin
                    nxt_out[n] = 1'b0;
                end else if (hit[0]) begin
                    nxt_out[n] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_ff  <= `TPWM_CNT_RST;
            pre_ff  <= `TPWM_CNT_RST;
            pend_ff <= '0;
            irq_ff  <= '0;
            stop_ff <= 1'b0;
            cap_ff  <= 1'b0;
            out_ff  <= '0;
            for (int i = 0; i < `TPWM_NUM_MATCH; i++) begin
                shadow_ff[i] <= `TPWM_MATCH_RST;
                active_ff[i] <= `TPWM_MATCH_RST;
            end
        end else begin
            cnt_ff  <= nxt_cnt;
            pre_ff  <= nxt_pre;
            pend_ff <= nxt_pend;
            irq_ff  <= nxt_irq;
            stop_ff <= nxt_stop;
            cap_ff  <= nxt_cap;
            out_ff  <= nxt_out;
            for (int i = 0; i < `TPWM_NUM_MATCH; i++) begin
                shadow_ff[i] <= nxt_shadow[i];
                active_ff[i] <= nxt_active[i];
            end
        end
    end

    // Checks.
    a_period_restart: assert property (@(posedge ref_clk) disable iff (reset)
        (ctrl.pwm_mode_en && hit[0] && !ctrl.counter_reset) |=> (cnt_ff == 32'h0000_0000))
        else $error("counter not restarted on period match");
    a_single_rise: assert property (@(posedge ref_clk) disable iff (reset)
        (ctrl.pwm_mode_en && ocfg.out_en[0] && !ocfg.dbl_edge[0] && hit[0] && !hit[1])
        |=> pwm_out[0])
        else $error("single-edge output did not rise");
    a_single_fall: assert property (@(posedge ref_clk) disable iff (reset)
        (ctrl.pwm_mode_en && ocfg.out_en[0] && !ocfg.dbl_edge[0] && hit[1]) |=> !pwm_out[0])
        else $error("single-edge output did not fall");
    a_double_rise: assert property (@(posedge ref_clk) disable iff (reset)
        (ctrl.pwm_mode_en && ocfg.out_en[1] && ocfg.dbl_edge[1] && hit[1] && !hit[2])
        |=> pwm_out[1])
        else $error("double-edge output did not rise");
    a_out_disabled: assert property (@(posedge ref_clk) disable iff (reset)
        !ctrl.pwm_mode_en |=> (pwm_out == '0))
        else $error("output driven outside pwm mode");
    a_stop_holds: assert property (@(posedge ref_clk) disable iff (reset)
        (stop_ff && ctrl.counter_en && !ctrl.counter_reset) |=> $stable(cnt_ff))
        else $error("counter moved while halted");
    a_irq_cause: assert property (@(posedge ref_clk) disable iff (reset)
        match_irq[0] |-> $past(hit[0]) && $past(mctl[0].action[0]))
        else $error("match interrupt without match");
    a_shadow_held: assert property (@(posedge ref_clk) disable iff (reset)
        (ctrl.pwm_mode_en && ctrl.counter_en && !hit[0]) |=> $stable(active_ff[1]))
        else $error("match applied mid-period");
    a_prescale_step: assert property (@(posedge ref_clk) disable iff (reset)
        (tick && pre_ff != prescale_max && !ctrl.counter_reset) |=> $stable(cnt_ff))
        else $error("counter advanced before prescaler terminal");
endmodule : tpwm_core

// *** verification/tpwm_load_model.sv ***
// Load model for the PWM pins: counts the cycles each pin spends high.
// Assumes pwm_out is registered on ref_clk; clr opens a new window.
`timescale 1ns/100ps
module tpwm_load_model (
    // Clock, reset and window start.
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             clr,
    // Pins driven by the unit and time seen high.
    input  wire logic [5:0]       pwm_out,
    output logic      [5:0][15:0] high_cnt
);
    // A load sees only the pin level, so the count is independent of window phase.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset)
            high_cnt <= '0;
        else if (clr)
            high_cnt <= '0;
        else
            for (int i = 0; i < 6; i++)
                high_cnt[i] <= high_cnt[i] + 16'(pwm_out[i]);
    end
endmodule : tpwm_load_model

// *** verification/tb_top.sv ***
// Bench for the timer-based PWM unit: random periods, widths and edge types.
// Assumes tpwm_pkg is compiled and tpwm_regs.svh is on the include path.
`timescale 1ns/100ps
`include "tpwm_regs.svh"
module tb_top;
    import tpwm_pkg::*;
    localparam int NP = 2;
    logic             ref_clk = 1'b0;
    logic             reset = 1'b1;
    tpwm_ctrl_t       ctrl = '0;
    tpwm_word_t       prescale_max = '0;
    tpwm_ocfg_t       ocfg = '0;
    tpwm_mctl_t [6:0] mctl = '0;
    logic             match_wr = 1'b0;
    logic [2:0]       match_sel = '0;
    tpwm_word_t       match_wdata = '0;
    logic [6:0]       latch_en = '0;
    logic [3:0]       cap_in = '0;
    logic [3:0]       nb;
    logic             clr = 1'b0;
    tpwm_word_t       count_val, prescale_val;
    logic [6:0]       match_irq, latch_pending;
    logic [5:0]       pwm_out;
    logic [5:0][15:0] high_cnt;
    int               n_fail = 0, check_count = 0, nirq = 0, seed = 32'h104020DC;
    int               per, pm, rises;
    tpwm_word_t       held;
    int               m [7];

    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) nirq <= clr ? 0 : nirq + int'(|match_irq);

    tpwm_core u_tpwm_core (.ref_clk(ref_clk), .reset(reset), .ctrl(ctrl),
        .prescale_max(prescale_max), .ocfg(ocfg), .mctl(mctl), .match_wr(match_wr),
        .match_sel(match_sel), .match_wdata(match_wdata), .latch_en(latch_en),
        .cap_in(cap_in), .count_val(count_val), .prescale_val(prescale_val),
        .match_irq(match_irq), .latch_pending(latch_pending), .pwm_out(pwm_out));
    tpwm_load_model u_tpwm_load_model (.ref_clk(ref_clk), .reset(reset), .clr(clr),
        .pwm_out(pwm_out), .high_cnt(high_cnt));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    // Shadow write, then an explicit release of that one match.
    task automatic wr_match(input int i, input int v);
        @(negedge ref_clk);
        match_wr = 1'b1;
        match_sel = 3'(i);
        match_wdata = v;
        @(negedge ref_clk);
        match_wr = 1'b0;
        latch_en[i] = 1'b1;
        @(negedge ref_clk);
        latch_en = '0;
    endtask : wr_match

    // High counts per period; double edge pairs match n (rise) with n+1 (fall).
    function automatic int exp_high(input int n);
        if (!ocfg.out_en[n] || !ctrl.pwm_mode_en)
            return 0;
        if (ocfg.dbl_edge[n] && n > 0)
            return (m[n+1] > m[n]) ? m[n+1] - m[n] : per + 1 - (m[n] - m[n+1]);
        return m[n+1] + 1;
    endfunction : exp_high

    task automatic report_and_stop;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    initial begin
        cyc(8);
        reset = 1'b0;
        cyc(1);
        chk(count_val, 0);
        chk(prescale_val, 0);
        chk({latch_pending, pwm_out}, 0);
        mctl[0].action[`TPWM_MCTL_INT_BIT] = 1'b1;
        mctl[0].action[`TPWM_MCTL_CLR_BIT] = 1'b1;
        for (int it = 0; it < 4; it++) begin
            pm = {$random(seed)} % 4;
            per = 8 + {$random(seed)} % 16;
            m[0] = per;
            for (int k = 1; k < 7; k++) begin
                m[k] = {$random(seed)} % per;
                if (m[k] == m[k-1])
                    m[k] = (m[k] + 1) % per;
            end
            ctrl = '0;
            ctrl.counter_reset = 1'b1;
            for (int k = 0; k < 7; k++)
                wr_match(k, m[k]);
            prescale_max = pm;
            ocfg = (it == 0) ? 12'hFEA : (it == 1) ? 12'hFC0 : 12'($random(seed));
            ctrl.pwm_mode_en = (it != 3);
            cyc(1);
            ctrl.counter_reset = 1'b0;
            ctrl.counter_en = 1'b1;
            cyc((per + 1) * (pm + 1) + 4);
            clr = 1'b1;
            cyc(1);
            clr = 1'b0;
            cyc(NP * (per + 1) * (pm + 1));
            for (int n = 0; n < 6; n++)
                chk(32'(high_cnt[n]), NP*(pm+1)*exp_high(n));
            chk(nirq, NP);
            if (ctrl.pwm_mode_en) begin
                wr_match(1, m[2]);
                chk(32'(latch_pending[1]), 1);
                cyc((per + 1) * (pm + 1) + 2);
                chk(32'(latch_pending[1]), 0);
            end
        end
        // Counter mode, rising edges only and then both edges of capture input 2.
        for (int e = 0; e < 2; e++) begin
            ctrl = '0;
            ctrl.counter_reset = 1'b1;
            ctrl.cap_sel = 2'h2;
            mctl = '0;
            prescale_max = '0;
            cyc(2);
            ctrl = '0;
            ctrl.counter_en = 1'b1;
            ctrl.count_mode = TPWM_MODE_COUNTER;
            ctrl.cap_sel = 2'h2;
            ctrl.cap_rise = 1'b1;
            ctrl.cap_fall = (e == 1);
            rises = 0;
            repeat (40) begin
                cyc(2);
                nb = 4'($random(seed));
                rises += int'((nb[2] != cap_in[2]) && (nb[2] || e == 1));
                cap_in = nb;
            end
            cyc(3);
            chk(count_val, rises);
        end
        // Halt on match 3: the count must freeze at 10 or 11 and raise a single interrupt.
        ctrl = '0;
        ctrl.counter_reset = 1'b1;
        mctl = '0;
        mctl[3].action[`TPWM_MCTL_STOP_BIT] = 1'b1;
        mctl[3].action[`TPWM_MCTL_INT_BIT] = 1'b1;
        wr_match(3, 10);
        ctrl.counter_reset = 1'b0;
        ctrl.counter_en = 1'b1;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(20);
        held = count_val;
        chk(32'(held == 32'h0000_000A || held == 32'h0000_000B), 1);
        cyc(10);
        chk(count_val, held);
        chk(nirq, 1);
        report_and_stop();
    end

    // The whole run needs under two thousand cycles; this leaves a wide margin.
    initial begin
        repeat (30000) @(posedge ref_clk);
        n_fail++;
        report_and_stop();
    end
endmodule : tb_top
